// File: see_params.svh
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// Byte address width of the 128 x 8 array
`define SEE_ADDR_W        7
// Target type code; the value is arbitrary
`define SEE_DEV_TYPE      4'h5
// Content of every location before any write
`define SEE_MEM_INIT      8'hFF
// Bit counter values: last data bit and acknowledge slot
`define SEE_LAST_BIT      4'h7
`define SEE_ACK_BIT       4'h8
`define SEE_CNT_ONE       4'h1
`define SEE_CNT_ZERO      4'h0
// Direction bit values in the target select byte
`define SEE_DIR_RD        1'h1
`define SEE_DIR_WR        1'h0
// Reference clock period and SCL period in ns
`define SEE_REF_PERIOD_NS 25
`define SEE_SCL_PERIOD_NS 10000
// Reference cycles in one quarter of an SCL period
`define SEE_QTR_CYCLES    (`SEE_SCL_PERIOD_NS / (4 * `SEE_REF_PERIOD_NS))
// Quarter phases of one SCL period
`define SEE_Q0            2'h0
`define SEE_Q1            2'h1
`define SEE_Q2            2'h2
`define SEE_Q3            2'h3
// Width of the sent-byte counter
`define SEE_CNT_W         16

`endif

// File: see_pkg.sv
package see_pkg;

    // Target end link states
    typedef enum logic [2:0] {
        DEV_STANDBY,
        DEV_SELECT,
        TARGET_SELECT_BYTE_ACK,
        DEV_ADDR,
        DEV_ADDR_ACK,
        DEV_SEND,
        DEV_MASTER_ACK,
        DEV_NEXT
    } see_dev_state_e;

    // Master bit engine states
    typedef enum logic [1:0] {
        MST_IDLE,
        MST_START,
        MST_BIT,
        MST_STOP
    } see_mst_state_e;

    // Kind of byte the master is moving
    typedef enum logic [1:0] {
        KIND_SEL_W,
        KIND_ADDR,
        KIND_SEL_R,
        KIND_DATA
    } see_byte_kind_e;

endpackage

// File: see_link_if.sv
interface see_link_if;
    logic scl;       // Clock driven by the master
    logic m_sda_out; // Master data output (always low)
    logic m_sda_oe;  // Master pulls SDA low while high
    logic d_sda_out; // Target data output (always low)
    logic d_sda_oe;  // Target pulls SDA low while high
    logic sda;       // Resolved open-drain level

    // Pulled up unless an enabled driver puts a low on the wire
    assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

    modport mst (output scl, output m_sda_out, output m_sda_oe, input sda);
    modport dev (input scl, output d_sda_out, output d_sda_oe, input sda);
endinterface

// File: see_eeprom_dev.sv
`include "see_params.svh"

// How it works
// - Repeated start, read select, send loaded byte
// - Master leaves single byte unacknowledged, stops
// - Acknowledged byte makes target send next
// - Master ends stream with no ack, stop
// - Address counter steps after every sent byte
// - Top address wraps to zero, output continues
// - Missing ack in ninth slot means standby
// - Master repeats upper seven select bits
// - Every location holds FFh before writes
// - Match type nibble, skip three, direction
// - Dummy write loads address counter only
// - Read select sends byte at counter
module see_eeprom_dev #(
    parameter int ADDR_W = `SEE_ADDR_W
) (
    input  wire logic                  link_clk_in,
    input  wire logic                  ref_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  clk_en_in,
    see_link_if.dev                    link,
    output logic                       standby_out,
    output logic [`SEE_CNT_W-1:0]      bytes_sent_out
);

    // Reset and enable carried into the link domain, bit 0 first stage
    logic [2:0]              rst_sync_reg;
    logic [2:0]              en_sync_reg;
    // Filtered reset and enable levels in the link domain
    logic                    rst_s2_reg;
    logic                    en_s2_reg;
    // Pin synchronisers, bit 0 first stage
    logic [2:0]              scl_sync_reg;
    logic [2:0]              sda_sync_reg;
    // Filtered pin levels
    logic                    scl_f_reg;
    logic                    sda_f_reg;
    // Link state
    see_pkg::see_dev_state_e state_reg;
    logic [3:0]              cnt_reg;
    logic [7:0]              shift_reg;
    logic [ADDR_W-1:0]       addr_reg;
    logic                    sda_oe_reg;
    logic                    read_reg;
    logic                    standby_lvl_reg;
    logic                    sent_tog_reg;
    // Array contents
    logic [7:0]              mem [2**ADDR_W];
    // Reference domain crossing
    logic [2:0]              stby_sync_reg;
    logic [2:0]              tog_sync_reg;
    logic                    tog_f_reg;

    // Filtered levels: a change counts once stages two and three agree
    wire scl_new = (scl_sync_reg[1] == scl_sync_reg[2]) ?
                   scl_sync_reg[2] : scl_f_reg;
    wire sda_new = (sda_sync_reg[1] == sda_sync_reg[2]) ?
                   sda_sync_reg[2] : sda_f_reg;
    // Clock edges and bus conditions
    wire scl_rise  = scl_new & ~scl_f_reg;
    wire scl_fall  = ~scl_new & scl_f_reg;
    wire start_det = scl_f_reg & scl_new & sda_f_reg & ~sda_new;
    wire stop_det  = scl_f_reg & scl_new & ~sda_f_reg & sda_new;
    // Byte counter step and end of byte
    wire [3:0] cnt_inc   = 4'(cnt_reg + `SEE_CNT_ONE);
    wire       byte_done = (cnt_reg == `SEE_LAST_BIT);
    // Select byte decode: type nibble, three ignored bits, direction
    wire sel_match = (shift_reg[7:4] == `SEE_DEV_TYPE);
    wire sel_read  = (shift_reg[0] == `SEE_DIR_RD);
    // Byte at the current counter position
    wire [7:0] mem_byte = mem[addr_reg];
    // Next address wraps from the top back to zero
    wire [ADDR_W-1:0] addr_inc = ADDR_W'(addr_reg + 1'b1);
    // Ninth slot held low by the master
    wire master_acked = ~sda_new;

    // Open-drain data: only ever pulls low
    assign link.d_sda_out = 1'b0;
    assign link.d_sda_oe  = sda_oe_reg;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge link_clk_in) begin
        rst_sync_reg <= {rst_sync_reg[1:0], reset_in};
        en_sync_reg  <= {en_sync_reg[1:0], clk_en_in};
        if (rst_sync_reg[1] == rst_sync_reg[2]) begin
            rst_s2_reg <= rst_sync_reg[2];
        end
        if (en_sync_reg[1] == en_sync_reg[2]) begin
            en_s2_reg <= en_sync_reg[2];
        end
    end

    // Three-stage pin synchronisers
    always_ff @(posedge link_clk_in) begin
        scl_sync_reg <= {scl_sync_reg[1:0], link.scl};
        sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
    end

    // Filtered levels, idle-high after reset
    always_ff @(posedge link_clk_in) begin
        if (rst_s2_reg) begin
            scl_f_reg <= 1'b1;
            sda_f_reg <= 1'b1;
        end else if (en_s2_reg) begin
            scl_f_reg <= scl_new;
            sda_f_reg <= sda_new;
        end
    end

    // Array starts out all ones; nothing here writes it
    always_ff @(posedge link_clk_in) begin
        if (rst_s2_reg) begin
            for (int i = 0; i < 2**ADDR_W; i++) begin
                mem[i] <= `SEE_MEM_INIT;
            end
        end
    end

    // Link sequencer: bits taken on SCL rise, driven on SCL fall
    always_ff @(posedge link_clk_in) begin
        if (rst_s2_reg) begin
            state_reg    <= see_pkg::DEV_STANDBY;
            cnt_reg      <= `SEE_CNT_ZERO;
            shift_reg    <= 8'h00;
            addr_reg     <= '0;
            sda_oe_reg   <= 1'b0;
            read_reg     <= 1'b0;
            sent_tog_reg <= 1'b0;
        end else if (en_s2_reg) begin
            if (start_det) begin
                // Any START, repeated or not, opens a select byte
                state_reg  <= see_pkg::DEV_SELECT;
                cnt_reg    <= `SEE_CNT_ZERO;
                sda_oe_reg <= 1'b0;
            end else if (stop_det) begin
                // STOP always ends the transfer
                state_reg  <= see_pkg::DEV_STANDBY;
                sda_oe_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    see_pkg::DEV_STANDBY: begin
                        // Line released, bus ignored until START
                        sda_oe_reg <= 1'b0;
                    end
                    see_pkg::DEV_SELECT,
                    see_pkg::DEV_ADDR: begin
                        // Shift in eight bits, MSB first
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_new};
                            cnt_reg   <= cnt_inc;
                            if (byte_done) begin
                                state_reg <= (state_reg ==
                                    see_pkg::DEV_SELECT) ?
                                    see_pkg::TARGET_SELECT_BYTE_ACK :
                                    see_pkg::DEV_ADDR_ACK;
                            end
                        end
                    end
                    see_pkg::TARGET_SELECT_BYTE_ACK: begin
                        if (scl_fall && !sda_oe_reg) begin
                            // Acknowledge a matching select only
                            if (sel_match) begin
                                sda_oe_reg <= 1'b1;
                                read_reg   <= sel_read;
                            end else begin
                                state_reg <= see_pkg::DEV_STANDBY;
                            end
                        end else if (scl_fall && read_reg) begin
                            // Read select: send byte at counter
                            shift_reg  <= mem_byte;
                            sda_oe_reg <= ~mem_byte[7];
                            cnt_reg    <= `SEE_CNT_ZERO;
                            state_reg  <= see_pkg::DEV_SEND;
                        end else if (scl_fall) begin
                            // Write select: byte address follows
                            sda_oe_reg <= 1'b0;
                            cnt_reg    <= `SEE_CNT_ZERO;
                            state_reg  <= see_pkg::DEV_ADDR;
                        end
                    end
                    see_pkg::DEV_ADDR_ACK: begin
                        if (scl_fall && !sda_oe_reg) begin
                            // Address byte loads the counter
                            sda_oe_reg <= 1'b1;
                            addr_reg   <= shift_reg[ADDR_W-1:0];
                        end else if (scl_fall) begin
                            // No data write here: wait for START
                            sda_oe_reg <= 1'b0;
                            state_reg  <= see_pkg::DEV_STANDBY;
                        end
                    end
                    see_pkg::DEV_SEND: begin
                        if (scl_rise) begin
                            cnt_reg <= cnt_inc;
                            if (byte_done) begin
                                // Byte out: step the counter
                                addr_reg     <= addr_inc;
                                sent_tog_reg <= ~sent_tog_reg;
                                state_reg    <= see_pkg::DEV_MASTER_ACK;
                            end
                        end else if (scl_fall) begin
                            // Put the next bit on the line
                            shift_reg  <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg <= ~shift_reg[6];
                        end
                    end
                    see_pkg::DEV_MASTER_ACK: begin
                        if (scl_fall) begin
                            // Free the line for the ninth slot
                            sda_oe_reg <= 1'b0;
                        end else if (scl_rise && master_acked) begin
                            state_reg <= see_pkg::DEV_NEXT;
                        end else if (scl_rise) begin
                            // No acknowledge: stop sending
                            state_reg <= see_pkg::DEV_STANDBY;
                        end
                    end
                    see_pkg::DEV_NEXT: begin
                        // Next byte with no new command
                        if (scl_fall) begin
                            shift_reg  <= mem_byte;
                            sda_oe_reg <= ~mem_byte[7];
                            cnt_reg    <= `SEE_CNT_ZERO;
                            state_reg  <= see_pkg::DEV_SEND;
                        end
                    end
                endcase
            end
        end
    end

    // Standby level for the reference domain
    always_ff @(posedge link_clk_in) begin
        if (rst_s2_reg) begin
            standby_lvl_reg <= 1'b1;
        end else if (en_s2_reg) begin
            standby_lvl_reg <= (state_reg == see_pkg::DEV_STANDBY);
        end
    end

    // Reference-side synchronisers for level and byte toggle
    always_ff @(posedge ref_clk_in) begin
        stby_sync_reg <= {stby_sync_reg[1:0], standby_lvl_reg};
        tog_sync_reg  <= {tog_sync_reg[1:0], sent_tog_reg};
    end

    // Status outputs in the reference domain
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            standby_out    <= 1'b1;
            tog_f_reg      <= 1'b0;
            bytes_sent_out <= '0;
        end else if (clk_en_in) begin
            if (stby_sync_reg[1] == stby_sync_reg[2]) begin
                standby_out <= stby_sync_reg[2];
            end
            if ((tog_sync_reg[1] == tog_sync_reg[2]) &&
                (tog_sync_reg[2] != tog_f_reg)) begin
                // One more byte left the target
                tog_f_reg      <= tog_sync_reg[2];
                bytes_sent_out <= `SEE_CNT_W'(bytes_sent_out + 1'b1);
            end
        end
    end

endmodule

// File: see_i2c_master.sv
`include "see_params.svh"

module see_i2c_master #(
    parameter int QTR_CYCLES = `SEE_QTR_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    see_link_if.mst          link,
    input  wire logic        go_in,
    input  wire logic        random_in,
    input  wire logic [6:0]  addr_in,
    input  wire logic [2:0]  sel_mid_in,
    input  wire logic [7:0]  count_in,
    output logic             busy_out,
    output logic [7:0]       data_out,
    output logic             data_valid_out,
    output logic             nack_out
);

    // Engine state and byte kind
    see_pkg::see_mst_state_e state_reg;
    see_pkg::see_byte_kind_e kind_reg;
    logic [15:0]             div_reg;   // Quarter-period divider
    logic [1:0]              q_reg;     // Quarter phase
    logic [3:0]              bit_reg;   // Bit slot 0..8
    logic [7:0]              tx_reg;    // Outgoing byte
    logic [7:0]              rx_reg;    // Incoming byte
    logic [7:0]              left_reg;  // Bytes still to read
    logic [6:0]              addr_reg;  // Latched byte address
    logic [2:0]              mid_reg;   // Latched middle select bits
    logic                    ack_reg;   // Ninth slot level
    logic                    scl_reg;   // SCL drive
    logic                    oe_reg;    // SDA pull-low
    logic [2:0]              sda_sync_reg;
    logic                    sda_f_reg;

    // Quarter tick and bit slot decode
    wire tick     = (div_reg == 16'(QTR_CYCLES - 1));
    wire ack_slot = (bit_reg == `SEE_ACK_BIT);
    wire is_data  = (kind_reg == see_pkg::KIND_DATA);
    wire last_rd  = (left_reg == 8'h01);
    // Same upper seven bits in both select bytes
    wire [7:0] sel_w = {`SEE_DEV_TYPE, mid_reg, `SEE_DIR_WR};
    wire [7:0] sel_r = {`SEE_DEV_TYPE, mid_reg, `SEE_DIR_RD};
    // Filtered SDA: change counts once stages two and three agree
    wire sda_new = (sda_sync_reg[1] == sda_sync_reg[2]) ?
                   sda_sync_reg[2] : sda_f_reg;
    // Drive in slot: data bits, or ack only if more bytes wanted
    wire drive_low = is_data ? (ack_slot & ~last_rd)
                             : (~ack_slot & ~tx_reg[7]);

    assign link.scl       = scl_reg;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe  = oe_reg;

    // SDA synchroniser from the target's domain
    always_ff @(posedge ref_clk_in) begin
        sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
    end

    // Divider producing quarter ticks of SCL
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || state_reg == see_pkg::MST_IDLE) begin
            div_reg <= 16'h0000;
        end else if (clk_en_in) begin
            div_reg <= tick ? 16'h0000 : 16'(div_reg + 1'b1);
        end
    end

    // Bus sequencer
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= see_pkg::MST_IDLE;
            kind_reg  <= see_pkg::KIND_SEL_R;
            q_reg <= `SEE_Q0;
            bit_reg <= `SEE_CNT_ZERO;
            {tx_reg, rx_reg, left_reg} <= '0;
            {addr_reg, mid_reg, ack_reg} <= '0;
            {scl_reg, sda_f_reg} <= 2'h3;
            oe_reg <= 1'b0;
            {busy_out, data_valid_out, nack_out} <= 3'h0;
            data_out <= 8'h00;
        end else if (clk_en_in) begin
            data_valid_out <= 1'b0;
            sda_f_reg <= sda_new;
            unique case (state_reg)
                see_pkg::MST_IDLE: begin
                    if (go_in) begin
                        // Random read opens with a dummy write
                        kind_reg <= random_in ? see_pkg::KIND_SEL_W
                                              : see_pkg::KIND_SEL_R;
                        addr_reg  <= addr_in;
                        mid_reg   <= sel_mid_in;
                        left_reg  <= (count_in == 8'h00) ? 8'h01 : count_in;
                        busy_out  <= 1'b1;
                        nack_out  <= 1'b0;
                        q_reg     <= `SEE_Q0;
                        state_reg <= see_pkg::MST_START;
                    end
                end
                see_pkg::MST_START: if (tick) begin
                    // Release, SCL high, SDA falls, SCL low
                    q_reg <= 2'(q_reg + 1'b1);
                    unique case (q_reg)
                        `SEE_Q0: oe_reg <= 1'b0;
                        `SEE_Q1: scl_reg <= 1'b1;
                        `SEE_Q2: oe_reg <= 1'b1;
                        `SEE_Q3: begin
                            scl_reg   <= 1'b0;
                            bit_reg   <= `SEE_CNT_ZERO;
                            tx_reg    <= (kind_reg == see_pkg::KIND_SEL_W) ?
                                         sel_w : sel_r;
                            state_reg <= see_pkg::MST_BIT;
                        end
                    endcase
                end
                see_pkg::MST_BIT: if (tick) begin
                    q_reg <= 2'(q_reg + 1'b1);
                    unique case (q_reg)
                        `SEE_Q0: oe_reg <= drive_low;
                        `SEE_Q1: scl_reg <= 1'b1;
                        `SEE_Q2: begin
                            if (ack_slot) begin
                                ack_reg <= sda_new;
                            end else begin
                                rx_reg <= {rx_reg[6:0], sda_new};
                                tx_reg <= {tx_reg[6:0], 1'b0};
                            end
                        end
                        `SEE_Q3: begin
                            scl_reg <= 1'b0;
                            bit_reg <= ack_slot ? `SEE_CNT_ZERO
                                                : 4'(bit_reg + `SEE_CNT_ONE);
                            if (ack_slot && !is_data && ack_reg) begin
                                // Target did not acknowledge
                                nack_out  <= 1'b1;
                                state_reg <= see_pkg::MST_STOP;
                            end else if (ack_slot) begin
                                unique case (kind_reg)
                                    see_pkg::KIND_SEL_W: begin
                                        kind_reg <= see_pkg::KIND_ADDR;
                                        tx_reg   <= {1'b0, addr_reg};
                                    end
                                    see_pkg::KIND_ADDR: begin
                                        // Repeated START for read phase
                                        kind_reg  <= see_pkg::KIND_SEL_R;
                                        state_reg <= see_pkg::MST_START;
                                    end
                                    see_pkg::KIND_SEL_R: begin
                                        kind_reg <= see_pkg::KIND_DATA;
                                    end
                                    see_pkg::KIND_DATA: begin
                                        data_out       <= rx_reg;
                                        data_valid_out <= 1'b1;
                                        left_reg <= 8'(left_reg - 1'b1);
                                        if (last_rd) begin
                                            state_reg <= see_pkg::MST_STOP;
                                        end
                                    end
                                endcase
                            end
                        end
                    endcase
                end
                see_pkg::MST_STOP: if (tick) begin
                    // SDA low, SCL high, SDA rises
                    q_reg <= 2'(q_reg + 1'b1);
                    unique case (q_reg)
                        `SEE_Q0: oe_reg <= 1'b1;
                        `SEE_Q1: scl_reg <= 1'b1;
                        `SEE_Q2: oe_reg <= 1'b0;
                        `SEE_Q3: begin
                            busy_out  <= 1'b0;
                            state_reg <= see_pkg::MST_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

endmodule

// File: see_link_chk.sv
// Watches the shared two-wire link from the reference clock
module see_link_chk (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic scl_in,
    input wire logic m_sda_out_in,
    input wire logic m_sda_oe_in,
    input wire logic d_sda_out_in,
    input wire logic d_sda_oe_in,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // Line idles released with the clock high
    a_reset_idle: assert property (
        $fell(reset_in) |-> scl_in && sda_in)
        else $error("link not idle after reset");
    // Both ends only ever pull low
    a_outs_low: assert property (!m_sda_out_in && !d_sda_out_in)
        else $error("sda driver not low");
    // Target data holds while the clock is high
    a_dev_hold: assert property (
        scl_in && $past(scl_in) |-> $stable(d_sda_oe_in))
        else $error("target changed sda with scl high");
    // Target starts driving only in the clock low phase
    a_dev_drive_low: assert property ($rose(d_sda_oe_in) |-> !scl_in)
        else $error("target began driving with scl high");
    // A START always finds the target released
    a_start_free: assert property (
        scl_in && $fell(sda_in) |-> !d_sda_oe_in)
        else $error("target driving at start");
    // From a STOP the target stays off the wire for 8 cycles
    a_stop_release: assert property (
        scl_in && $rose(sda_in) |-> !d_sda_oe_in [*8])
        else $error("target drove after stop");
    // Clock high and low phases hold for at least 8 cycles after each edge
    a_scl_high_width: assert property ($rose(scl_in) |=> scl_in [*8])
        else $error("scl high too short");
    a_scl_low_width: assert property ($fell(scl_in) |=> !scl_in [*8])
        else $error("scl low too short");
    c_stop: cover property (scl_in && $rose(sda_in));
    c_start: cover property (scl_in && $fell(sda_in));
    c_dev_drive: cover property ($rose(d_sda_oe_in));
endmodule

// File: tb_serial_eeprom_read_modes.sv
module tb_serial_eeprom_read_modes;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_in = 1'b0; // Reference clock, 25 ns
    logic        link_clk   = 1'b0; // Target oversampling clock, 15 ns
    logic        reset_in   = 1'b1; // Synchronous reset
    logic        go_in = 1'b0, random_in = 1'b0;
    logic [6:0]  addr_in    = 7'h00;
    logic [2:0]  sel_mid_in = 3'h0;
    logic [7:0]  count_in   = 8'h01, data_w;
    logic        busy_w, valid_w, nack_w, standby_w;
    logic [15:0] sent_w, base;
    int          err_total = 0, cmp_count = 0, got, i;
    see_link_if link_w ();
    see_i2c_master #(.QTR_CYCLES(8)) see_i2c_master_i (.ref_clk_in,
        .reset_in, .clk_en_in(1'b1), .link(link_w), .go_in, .random_in,
        .addr_in, .sel_mid_in, .count_in, .busy_out(busy_w),
        .data_out(data_w), .data_valid_out(valid_w), .nack_out(nack_w));
    see_eeprom_dev see_eeprom_dev_i (.link_clk_in(link_clk), .ref_clk_in,
        .reset_in, .clk_en_in(1'b1), .link(link_w),
        .standby_out(standby_w), .bytes_sent_out(sent_w));
    see_link_chk see_link_chk_i (.ref_clk_in, .reset_in,
        .scl_in(link_w.scl),
        .m_sda_out_in(link_w.m_sda_out), .m_sda_oe_in(link_w.m_sda_oe),
        .d_sda_out_in(link_w.d_sda_out), .d_sda_oe_in(link_w.d_sda_oe),
        .sda_in(link_w.sda));
    // Clocks with unrelated phase
    always #12.5 ref_clk_in = ~ref_clk_in;
    initial begin
        #4;
        forever #7.5 link_clk = ~link_clk;
    end
    // Compare and count
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One read transfer; every byte must read back erased
    task run(input logic rnd, input logic [6:0] a, input logic [2:0] m,
             input logic [7:0] n);
        @(negedge ref_clk_in);
        base = sent_w;
        @(posedge ref_clk_in);
        go_in <= 1'b1;
        random_in <= rnd;
        addr_in <= a;
        sel_mid_in <= m;
        count_in <= n;
        @(posedge ref_clk_in);
        go_in <= 1'b0;
        got = 0;
        i = 0;
        // Gather bytes until the master drops busy
        while (i == 0 || busy_w !== 1'b0) begin
            @(negedge ref_clk_in);
            i++;
            if (valid_w === 1'b1) begin
                check({8'h00, data_w}, 16'h00FF);
                got++;
            end
        end
        repeat (8) @(negedge ref_clk_in);
        check(16'(got), {8'h00, n});
        check({15'h0000, nack_w}, 16'h0000);
        check(sent_w - base, {8'h00, n});
        check({15'h0000, standby_w}, 16'h0001);
    endtask
    task t_random_one;
        run(1'b1, 7'h10, 3'h2, 8'h01);
        check({9'h000, see_eeprom_dev_i.addr_reg}, 16'h0011);
        $display("test random single done");
    endtask
    task t_wrap_stream;
        run(1'b1, 7'h7E, 3'h5, 8'h04);
        check({9'h000, see_eeprom_dev_i.addr_reg}, 16'h0002);
        $display("test wrap stream done");
    endtask
    task t_current;
        run(1'b0, 7'h00, 3'h7, 8'h02);
        check({9'h000, see_eeprom_dev_i.addr_reg}, 16'h0004);
        $display("test current address done");
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        t_random_one();
        t_wrap_stream();
        t_current();
        tally_and_finish();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        err_total++;
        tally_and_finish();
    end
endmodule
